// ---- src/mdd_desc_dma.sv ----
// Descriptor DMA engine for the Ethernet MAC: walks linked receive and transmit
// descriptors in system memory, hands buffers to the MAC and writes status back.
// Assumes a memory port that holds ack high for one cycle per completed access,
// and MAC paths that move the frame bytes themselves.
//
// Function
// [R01] Receive owner 00 CPU, 10 controller
// [R02] Receive done: owner 00, or 11 translated
// [R03] Software returns receive descriptor with 10
// [R04] Runt under 64, oversize over 1518
// [R05] Flag CRC mismatch and odd bit length
// [R06] Flag frame stored and interrupt cause
// [R07] Length includes FCS unless strip_fcs set
// [R08] Receive buffer at base plus byte offset
// [R09] Word 3 link, low two bits ignored
// [R10] Transmit done clears owner bit 31
// [R11] Software sets owner bit after preparing
// [R12] tx_irq_enable gates completion interrupt
// [R13] fcs_append requests 4-byte CRC
// [R14] pad_enable pads frames under 60 bytes
// [R15] Transmit reads tx_length bytes from base+offset
// [R16] Sixteen collisions abort, tally zero, flag
// [R17] Heartbeat check only 10M half duplex
// [R18] Flag pause hold and halted transmit
// [R19] Late collision after 64 bytes, half duplex
// [R20] No carrier during send, half duplex
// [R21] Excess deferral limit per speed
// [R22] Done, irq and deferred-once flags
// [R23] Receive descriptor is four words
// [R24] Follow links, stop at CPU-owned descriptor
`include "mdd_cfg.svh"
`default_nettype none

module mdd_desc_dma #(
   parameter int DEFER100_CYC = `MDD_DEFER100_CYC,
   parameter int DEFER10_CYC  = `MDD_DEFER10_CYC
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic [4:0]     avs_address,
   input  wire logic           avs_read,
   input  wire logic           avs_write,
   input  wire logic [31:0]    avs_writedata,
   input  wire logic [3:0]     avs_byteenable,
   output logic [31:0]         avs_readdata,
   output logic                avs_waitrequest,
   output mdd_pkg::mdd_mem_t   memReq,
   input  wire logic           memAck,
   input  wire logic [31:0]    memRdata,
   output logic                rxBufReady,
   output logic [31:0]         rxBufAddr,
   input  wire mdd_pkg::mdd_rxres_t rxRes,
   output mdd_pkg::mdd_txcmd_t txCmd,
   input  wire mdd_pkg::mdd_txres_t txRes,
   output logic                txIrq
);

   mdd_pkg::mdd_regs_t q;
   mdd_pkg::mdd_regs_t d;

   logic        halfDup;
   logic        busReq;
   logic [31:0] wmask;
   logic [31:0] wbWord;
   logic [15:0] rxLen;
   logic        txEnd;
   logic [16:0] deferLim;

   assign halfDup = ~q.ctrl[`MDD_CTL_FULLDUP];
   assign busReq  = avs_read | avs_write;
   assign deferLim = q.ctrl[`MDD_CTL_SPEED100] ? 17'(DEFER100_CYC) : 17'(DEFER10_CYC);

   // Byte lanes of a write
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{avs_byteenable[b]}};
   end

   always_comb begin
      d = q;
      d.ack = busReq & ~q.ack;
      d.tx.start = 1'b0;
      d.tx.abort = 1'b0;
      d.txIrq = 1'b0;
      rxLen = 16'h0000;
      txEnd = 1'b0;
      wbWord = 32'h0000_0000;

      // Register reads are captured in the wait cycle so data stand at the accept edge
      if (avs_read && !q.ack) begin
         unique case (avs_address)
            `MDD_OFF_CTRL:   d.rdata = {24'h00_0000, q.ctrl};
            `MDD_OFF_TXHEAD: d.rdata = q.txHead;
            `MDD_OFF_RXHEAD: d.rdata = q.rxHead;
            `MDD_OFF_STATUS: d.rdata = {26'h000_0000, q.st, q.txStall, q.rxStall, q.isTx};
            default:         d.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && q.ack) begin
         unique case (avs_address)
            `MDD_OFF_CTRL:   d.ctrl = (q.ctrl & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
            `MDD_OFF_TXHEAD: d.txHead = ((q.txHead & ~wmask) | (avs_writedata & wmask))
                                        & `MDD_WORD_MASK; // R09
            `MDD_OFF_RXHEAD: d.rxHead = ((q.rxHead & ~wmask) | (avs_writedata & wmask))
                                        & `MDD_WORD_MASK; // R09
            `MDD_OFF_DEMAND: begin
               if (avs_byteenable[0] && avs_writedata[0]) d.rxStall = 1'b0;
               if (avs_byteenable[0] && avs_writedata[1]) d.txStall = 1'b0;
            end
            default: ;
         endcase
      end

      unique case (q.st)
         mdd_pkg::MDD_IDLE: begin
            // Alternate between the two rings so neither starves
            if (q.ctrl[`MDD_CTL_TXRUN] && !d.txStall
                && (!q.lastTx || !q.ctrl[`MDD_CTL_RXRUN] || d.rxStall)) begin
               d.isTx = 1'b1;
               d.lastTx = 1'b1;
               d.idx = 2'h0;
               d.st = mdd_pkg::MDD_FETCH;
               d.mem = '{req: 1'b1, we: 1'b0, addr: q.txHead, wdata: 32'h0000_0000};
            end else if (q.ctrl[`MDD_CTL_RXRUN] && !d.rxStall) begin
               d.isTx = 1'b0;
               d.lastTx = 1'b0;
               d.idx = 2'h0;
               d.st = mdd_pkg::MDD_FETCH;
               d.mem = '{req: 1'b1, we: 1'b0, addr: q.rxHead, wdata: 32'h0000_0000};
            end
         end

         mdd_pkg::MDD_FETCH: begin
            if (memAck) begin
               d.mem.req = 1'b1;
               d.mem.addr = q.mem.addr + 32'h0000_0004;
               d.idx = q.idx + 2'h1;
               unique case (q.idx)
                  2'h0: begin
                     d.w0 = memRdata;
                     // A descriptor still held by the CPU ends the walk
                     if (q.isTx && memRdata[31] != `MDD_TX_OWN_DEV) begin // R10
                        d.txStall = 1'b1; // R24
                        d.mem.req = 1'b0;
                        d.st = mdd_pkg::MDD_IDLE;
                     end else if (!q.isTx && memRdata[31:30] != `MDD_RX_OWN_DEV) begin // R01
                        d.rxStall = 1'b1; // R24
                        d.mem.req = 1'b0;
                        d.st = mdd_pkg::MDD_IDLE;
                     end
                  end
                  2'h1: begin
                     d.bufAddr = memRdata;
                     // Word 2 of a receive descriptor carries nothing; skip it
                     if (!q.isTx) begin // R23
                        d.idx = 2'h3;
                        d.mem.addr = q.mem.addr + 32'h0000_0008;
                     end
                  end
                  2'h2: d.len = memRdata[15:0]; // R15
                  2'h3: begin
                     d.next = memRdata & `MDD_WORD_MASK; // R09
                     d.mem.req = 1'b0;
                     if (q.isTx) begin
                        d.tx.start = 1'b1;
                        d.tx.addr = q.bufAddr; // R15
                        d.tx.fcs = q.w0[`MDD_TXW0_FCS]; // R13
                        d.tx.len = (q.w0[`MDD_TXW0_PAD] && q.len < `MDD_PAD_BYTES)
                                   ? `MDD_PAD_BYTES : q.len; // R14
                        d.coll = 4'h0;
                        d.late = 1'b0;
                        d.noCar = 1'b0;
                        d.postponed = 1'b0;
                        d.excess_wait_flag = 1'b0;
                        d.abort = 1'b0;
                        d.deferCnt = 17'h0_0000;
                        d.st = mdd_pkg::MDD_TX_SEND;
                     end else begin
                        d.rxReady = 1'b1; // R08
                        d.st = mdd_pkg::MDD_RX_WAIT;
                     end
                  end
                  default: ;
               endcase
            end
         end

         mdd_pkg::MDD_RX_WAIT: begin
            if (rxRes.done) begin
               rxLen = q.ctrl[`MDD_CTL_STRIPFCS] ? rxRes.len - `MDD_FCS_BYTES : rxRes.len; // R07
               wbWord[31:30] = rxRes.nat ? `MDD_RX_OWN_NAT : `MDD_RX_OWN_CPU; // R02
               wbWord[22] = rxRes.len < `MDD_RUNT_BYTES; // R04
               wbWord[21] = rxRes.oddBits; // R05
               wbWord[20] = 1'b1; // R06
               wbWord[19] = rxRes.len > `MDD_MAX_BYTES; // R04
               wbWord[17] = rxRes.crcBad; // R05
               wbWord[16] = rxRes.irq; // R06
               wbWord[15:0] = rxLen; // R07
               d.rxReady = 1'b0;
               d.mem = '{req: 1'b1, we: 1'b1, addr: q.rxHead, wdata: wbWord};
               d.st = mdd_pkg::MDD_RX_WB;
            end
         end

         mdd_pkg::MDD_RX_WB: begin
            if (memAck) begin
               d.mem.req = 1'b0;
               d.rxHead = q.next; // R24
               d.st = mdd_pkg::MDD_IDLE;
            end
         end

         mdd_pkg::MDD_TX_SEND: begin
            if (halfDup) begin
               if (txRes.collision) begin
                  d.coll = q.coll + 4'h1; // R16
                  if (txRes.sentBytes >= `MDD_LATE_BYTES) d.late = 1'b1; // R19
                  if (q.coll == `MDD_COLL_LAST) begin
                     d.abort = 1'b1; // R16
                     d.tx.abort = 1'b1;
                     txEnd = 1'b1;
                  end
               end
               if (!txRes.carrier) d.noCar = 1'b1; // R20
               if (txRes.deferring) begin
                  d.postponed = 1'b1; // R22
                  if (q.deferCnt != deferLim) d.deferCnt = q.deferCnt + 17'h0_0001;
                  else if (!q.ctrl[`MDD_CTL_NODEFER]) d.excess_wait_flag = 1'b1; // R21
               end
            end
            if (txRes.done) txEnd = 1'b1;
            if (txEnd) begin
               wbWord[31:28] = d.coll; // R16
               wbWord[26] = q.ctrl[`MDD_CTL_HBCHECK] && halfDup
                            && !q.ctrl[`MDD_CTL_SPEED100] && txRes.heartbeatMissing; // R17
               wbWord[25] = txRes.pauseRx | q.ctrl[`MDD_CTL_SENDPAUSE]; // R18
               wbWord[24] = ~q.ctrl[`MDD_CTL_TXRUN]; // R18
               wbWord[23] = d.late; // R19
               wbWord[22] = d.abort; // R16
               wbWord[21] = d.noCar; // R20
               wbWord[20] = d.excess_wait_flag; // R21
               wbWord[19] = ~d.abort; // R22
               wbWord[17] = d.postponed; // R22
               wbWord[16] = q.w0[`MDD_TXW0_IRQEN]; // R22
               wbWord[15:0] = q.len;
               d.mem = '{req: 1'b1, we: 1'b1, addr: q.txHead + 32'h0000_0008, wdata: wbWord};
               d.st = mdd_pkg::MDD_TX_WB2;
            end
         end

         // Status is written before ownership so software never sees a stale word 2
         mdd_pkg::MDD_TX_WB2: begin
            if (memAck) begin
               d.mem = '{req: 1'b1, we: 1'b1, addr: q.txHead, wdata: {1'b0, q.w0[30:0]}}; // R10
               d.st = mdd_pkg::MDD_TX_WB0;
            end
         end

         mdd_pkg::MDD_TX_WB0: begin
            if (memAck) begin
               d.mem.req = 1'b0;
               d.txIrq = q.w0[`MDD_TXW0_IRQEN]; // R12
               d.txHead = q.next; // R24
               d.st = mdd_pkg::MDD_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.txHead <= `MDD_HEAD_RESET;
         q.rxHead <= `MDD_HEAD_RESET;
      end else begin
         q <= d;
      end
   end

   assign avs_waitrequest = busReq & ~q.ack;
   assign avs_readdata = q.rdata;
   assign memReq = q.mem;
   assign rxBufReady = q.rxReady;
   assign rxBufAddr = q.bufAddr; // R08
   assign txCmd = q.tx;
   assign txIrq = q.txIrq;

endmodule
`default_nettype wire

// ---- common/mdd_cfg.svh ----
// Constants of the MAC descriptor DMA: register offsets, descriptor fields, timing.
// Assumes a 25 MHz system clock and 32-bit Avalon-MM software access.
`ifndef MDD_CFG_SVH
`define MDD_CFG_SVH

`define MDD_CLK_NS          40
// Register byte offsets
`define MDD_OFF_CTRL        5'h00
`define MDD_OFF_TXHEAD      5'h04
`define MDD_OFF_RXHEAD      5'h08
`define MDD_OFF_STATUS      5'h0C
`define MDD_OFF_DEMAND      5'h10
// Control register bits
`define MDD_CTL_RXRUN       0
`define MDD_CTL_TXRUN       1
`define MDD_CTL_STRIPFCS    2
`define MDD_CTL_HBCHECK     3
`define MDD_CTL_NODEFER     4
`define MDD_CTL_SENDPAUSE   5
`define MDD_CTL_FULLDUP     6
`define MDD_CTL_SPEED100    7
// Descriptor codes and fields
`define MDD_RX_OWN_CPU      2'h0
`define MDD_RX_OWN_DEV      2'h2
`define MDD_RX_OWN_NAT      2'h3
`define MDD_TX_OWN_DEV      1'h1
`define MDD_TXW0_IRQEN      2
`define MDD_TXW0_FCS        1
`define MDD_TXW0_PAD        0
`define MDD_HEAD_RESET      32'hFFFF_FFFC
`define MDD_WORD_MASK       32'hFFFF_FFFC
`define MDD_FCS_BYTES       16'h0004
`define MDD_RUNT_BYTES      16'h0040
`define MDD_MAX_BYTES       16'h05EE
`define MDD_PAD_BYTES       16'h003C
`define MDD_LATE_BYTES      16'h0040
`define MDD_COLL_LAST       4'hF
// Deferral limits in ns and their cycle counts
`define MDD_DEFER100_NS     327680
`define MDD_DEFER10_NS      3276800
`define MDD_DEFER100_CYC    (`MDD_DEFER100_NS / `MDD_CLK_NS)
`define MDD_DEFER10_CYC     (`MDD_DEFER10_NS / `MDD_CLK_NS)

`endif

// ---- common/mdd_pkg.sv ----
// Types of the MAC descriptor DMA.
// Assumes mdd_cfg.svh is compiled alongside for the constants.
`default_nettype none
package mdd_pkg;

   typedef enum logic [2:0] {
      MDD_IDLE, MDD_FETCH, MDD_RX_WAIT, MDD_RX_WB, MDD_TX_SEND, MDD_TX_WB2, MDD_TX_WB0
   } mdd_state_t;

   // Memory request towards the system bus bridge
   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mdd_mem_t;

   // Frame request towards the MAC transmit path
   typedef struct packed {
      logic        start;
      logic        abort;
      logic [31:0] addr;
      logic [15:0] len;
      logic        fcs;
   } mdd_txcmd_t;

   // Outcome of one received frame, from the MAC receive path
   typedef struct packed {
      logic        done;
      logic [15:0] len;
      logic        oddBits;
      logic        crcBad;
      logic        nat;
      logic        irq;
   } mdd_rxres_t;

   // Live transmit conditions from the MAC
   typedef struct packed {
      logic        done;
      logic        collision;
      logic [15:0] sentBytes;
      logic        carrier;
      logic        deferring;
      logic        heartbeatMissing;
      logic        pauseRx;
   } mdd_txres_t;

   typedef struct packed {
      mdd_state_t  st;
      logic [1:0]  idx;
      logic        isTx;
      logic        lastTx;
      logic [7:0]  ctrl;
      logic [31:0] txHead;
      logic [31:0] rxHead;
      logic        txStall;
      logic        rxStall;
      mdd_mem_t    mem;
      logic [31:0] w0;
      logic [31:0] bufAddr;
      logic [15:0] len;
      logic [31:0] next;
      logic        rxReady;
      mdd_txcmd_t  tx;
      logic [3:0]  coll;
      logic        late;
      logic        noCar;
      logic        postponed;
      logic        excess_wait_flag;
      logic        abort;
      logic [16:0] deferCnt;
      logic        txIrq;
      logic        ack;
      logic [31:0] rdata;
   } mdd_regs_t;

endpackage
`default_nettype wire

// ---- test/mdd_desc_chk.sv ----
// Port assertions for the descriptor DMA.
// Assumes binding into mdd_desc_dma; one clock, synchronous active-low reset.
`default_nettype none
module mdd_desc_chk (
   input wire logic                clk,
   input wire logic                rst_n,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic                avs_waitrequest,
   input wire mdd_pkg::mdd_mem_t   memReq,
   input wire logic                memAck,
   input wire logic                rxBufReady,
   input wire mdd_pkg::mdd_rxres_t rxRes,
   input wire mdd_pkg::mdd_txcmd_t txCmd,
   input wire logic                txIrq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   chk_wait_one:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access waited more than one cycle");
   chk_idle_free:
      assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest without a request");
   chk_req_hold:
      assert property (memReq.req && !memAck |=> memReq.req && $stable(memReq.addr))
      else $error("memory request dropped or moved before ack");
   chk_mem_align:
      assert property (memReq.req |-> memReq.addr[1:0] == 2'b00)
      else $error("memory access not word aligned");
   chk_start_pulse:
      assert property (txCmd.start |=> !txCmd.start)
      else $error("frame start longer than one cycle");
   chk_irq_cause:
      assert property (txIrq |-> $past(memAck) && $past(memReq.we) && !$past(memReq.wdata[31]))
      else $error("transmit irq without owner release");
   chk_rx_release:
      assert property (rxRes.done && rxBufReady |=> !rxBufReady)
      else $error("receive buffer kept after frame end");
   chk_rx_owner:
      assert property (rxRes.done && rxBufReady && !rxRes.nat |-> ##[1:40]
         (memReq.req && memReq.we && memReq.wdata[31:30] == 2'b00 && memReq.wdata[20]))
      else $error("receive status not returned to software");
   chk_tx_abort:
      assert property (txCmd.abort |-> ##[1:40]
         (memReq.req && memReq.we && memReq.wdata[22] && memReq.wdata[31:28] == 4'h0))
      else $error("abort status not written");
   cover property (txCmd.start);
   cover property (txCmd.abort);
   cover property (rxRes.done && rxBufReady);
endmodule
bind mdd_desc_dma mdd_desc_chk i_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .memReq(memReq),
   .memAck(memAck), .rxBufReady(rxBufReady), .rxRes(rxRes), .txCmd(txCmd), .txIrq(txIrq));
`default_nettype wire

// ---- test/mdd_mem_model.sv ----
// Behavioural system memory shared by software and the DMA.
// Assumes the DMA holds a request until memAck; lat sets the extra wait cycles.
`default_nettype none
module mdd_mem_model (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [1:0]        lat,
   input  wire mdd_pkg::mdd_mem_t memReq,
   output logic                   memAck,
   output logic [31:0]            memRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:255];
   logic [1:0]  cnt;
   always @(posedge clk) begin
      memAck <= 1'b0;
      // Read data is not held after the ack, so stale values cannot pass
      memRdata <= ~memRdata;
      if (!rst_n) begin
         cnt <= 2'h0;
         memRdata <= 32'h5A5A_A5A5;
      end else if (memReq.req && !memAck) begin
         if (cnt >= lat) begin
            cnt <= 2'h0;
            memAck <= 1'b1;
            if (memReq.we) mem[memReq.addr[9:2]] <= memReq.wdata;
            else memRdata <= mem[memReq.addr[9:2]];
         end else cnt <= cnt + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench for the descriptor DMA: software via Avalon, memory model, MAC stubs.
// Assumes the memory model answers every request; clock 25 MHz.
`include "mdd_cfg.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, avsRead, avsWrite, avsWait, memAck, rxBufReady, txIrq;
   logic [4:0] avsAddress;
   logic [1:0] lat;
   logic [31:0] avsWdata, avsRdata, memRdata, rxBufAddr;
   mdd_pkg::mdd_mem_t memReq;
   mdd_pkg::mdd_rxres_t rxRes;
   mdd_pkg::mdd_txcmd_t txCmd;
   mdd_pkg::mdd_txres_t txRes;
   int mismatches = 0, testsRun = 0, cycles = 0, irqCount = 0;
   mdd_desc_dma #(.DEFER100_CYC(20), .DEFER10_CYC(50)) i_dut (.clk(clk), .rst_n(rst_n),
      .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
      .avs_writedata(avsWdata), .avs_byteenable(4'hF), .avs_readdata(avsRdata),
      .avs_waitrequest(avsWait), .memReq(memReq), .memAck(memAck), .memRdata(memRdata),
      .rxBufReady(rxBufReady), .rxBufAddr(rxBufAddr), .rxRes(rxRes), .txCmd(txCmd),
      .txRes(txRes), .txIrq(txIrq));
   mdd_mem_model i_mem (.clk(clk), .rst_n(rst_n), .lat(lat), .memReq(memReq),
      .memAck(memAck), .memRdata(memRdata));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      testsRun++;
      if (seen !== want) begin
         mismatches++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", testsRun, mismatches);
      if (mismatches == 0 && testsRun > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWdata <= d;
      do @(posedge clk); while (avsWait !== 1'b0);
      q = avsRdata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (txIrq === 1'b1) irqCount <= irqCount + 1;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      logic [31:0] q;
      logic [3:0] fl;
      logic [2:0] ctl [4];
      logic hbMiss;
      int i, base, strip, nd, sp, tl [4];
      int lens [4];
      {rst_n, avsRead, avsWrite, avsAddress, avsWdata, lat} = '0;
      lens = '{63, 64, 1518, 1519};
      rxRes = '0;
      txRes = '0;
      txRes.carrier = 1'b1;
      void'($urandom(49902));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, `MDD_OFF_TXHEAD, 32'h0000_0000, q);
      check(q, 32'hFFFF_FFFC);
      bus(0, `MDD_OFF_RXHEAD, 32'h0000_0000, q);
      check(q, 32'hFFFF_FFFC);
      bus(0, 5'h14, 32'h0000_0000, q);
      check(q, 32'h0000_0000);
      $display("register reset test done");
      strip = $urandom_range(1, 0);
      nd = $urandom_range(1, 0);
      sp = $urandom_range(1, 0);
      for (i = 0; i < 4; i++) begin
         ctl[i] = 3'($urandom_range(7, 0));
         tl[i] = $urandom_range(100, 20);
         i_mem.mem[128 + 4 * i] = {1'(i < 3), 28'h0, ctl[i]};
         i_mem.mem[129 + 4 * i] = 32'h1000_0000 + 32'(i);
         i_mem.mem[130 + 4 * i] = {16'h0000, 16'(tl[i])};
         i_mem.mem[131 + 4 * i] = 32'h0000_0210 + 32'(16 * i);
      end
      bus(1, `MDD_OFF_CTRL, 32'h0000_000A | 32'(strip << 2) | 32'(nd << 4) | 32'(sp << 5), q);
      bus(1, `MDD_OFF_TXHEAD, 32'h0000_0200, q);
      bus(1, `MDD_OFF_DEMAND, 32'h0000_0002, q);
      for (i = 0; i < 3; i++) begin
         base = irqCount;
         while (txCmd.start !== 1'b1) @(negedge clk);
         check(txCmd.addr, 32'h1000_0000 + 32'(i));
         check(txCmd.len, (ctl[i][0] && tl[i] < 60) ? 60 : tl[i]);
         check(txCmd.fcs, ctl[i][1]);
         hbMiss = (i == 0) ? 1'($urandom_range(1, 0)) : 1'b0;
         @(posedge clk);
         lat <= 2'($urandom_range(3, 0));
         txRes.heartbeatMissing <= hbMiss;
         txRes.pauseRx <= (i == 0);
         txRes.sentBytes <= (i == 1) ? 16'h0040 : 16'h0008;
         txRes.deferring <= (i == 1);
         // Carrier lost during the first frame only; restored once that frame ends
         txRes.carrier <= (i != 0);
         repeat ((i == 2) ? 16 : i) begin
            @(posedge clk);
            txRes.collision <= 1'b1;
            @(posedge clk);
            txRes.collision <= 1'b0;
         end
         repeat (60) @(posedge clk);
         txRes.deferring <= 1'b0;
         if (i != 2) begin
            txRes.done <= 1'b1;
            @(posedge clk);
            txRes.done <= 1'b0;
            txRes.carrier <= 1'b1;
         end
         while (i_mem.mem[128 + 4 * i][31] !== 1'b0) @(negedge clk);
         repeat (2) @(negedge clk);
         check(i_mem.mem[128 + 4 * i], {29'h0, ctl[i]});
         check(i_mem.mem[130 + 4 * i][31:16], {(i == 1) ? 4'h1 : 4'h0, 1'b0, hbMiss,
            i == 0 || sp != 0, 1'b0, i == 1, i == 2, i == 0, i == 1 && nd == 0, i != 2,
            1'b0, i == 1, ctl[i][2]});
         check(irqCount - base, 32'(ctl[i][2]));
         $display("tx frame %0d done", i);
      end
      repeat (20) @(negedge clk);
      bus(0, `MDD_OFF_STATUS, 32'h0000_0000, q);
      check(q & 32'h0000_0004, 32'h0000_0004);
      for (i = 0; i < 4; i++) begin
         i_mem.mem[16 + 4 * i] = {(i == 3) ? 2'b00 : 2'b10, 30'h0};
         i_mem.mem[17 + 4 * i] = 32'h2000_0000 + 32'(257 * i);
         i_mem.mem[18 + 4 * i] = 32'h5555_5555;
         i_mem.mem[19 + 4 * i] = 32'h0000_0051 + 32'(16 * i);
      end
      bus(1, `MDD_OFF_RXHEAD, 32'h0000_0040, q);
      bus(1, `MDD_OFF_CTRL, 32'h0000_000B | 32'(strip << 2), q);
      bus(1, `MDD_OFF_DEMAND, 32'h0000_0001, q);
      for (i = 0; i < 4; i++) begin
         if (i == 3) begin
            repeat (20) @(negedge clk);
            check(rxBufReady, 1'b0);
            i_mem.mem[28] = 32'h8000_0000;
            bus(1, `MDD_OFF_DEMAND, 32'h0000_0001, q);
         end
         while (rxBufReady !== 1'b1) @(negedge clk);
         check(rxBufAddr, 32'h2000_0000 + 32'(257 * i));
         fl = 4'($urandom_range(15, 0));
         @(posedge clk);
         rxRes <= {1'b1, 16'(lens[i]), fl[2], fl[1], fl[3], fl[0]};
         @(posedge clk);
         rxRes.done <= 1'b0;
         while (i_mem.mem[16 + 4 * i][31:30] === 2'b10) @(negedge clk);
         check(i_mem.mem[16 + 4 * i], {fl[3] ? 2'b11 : 2'b00, 7'h0, lens[i] < 64, fl[2], 1'b1,
            lens[i] > 1518, 1'b0, fl[1], fl[0], 16'(lens[i] - 4 * strip)});
         $display("rx frame %0d done", i);
      end
      close_out();
   end
endmodule
`default_nettype wire
